//--- logic/sfdp_basic_table.sv
// sfdp_basic_table: serial read command front end for the basic parameter table
// assumes: host drives cs_n, sclk and si asynchronously, sclk slower than clk / 8,
// cs_n low at least four clk periods before the first sclk edge; spi mode 0 or 3
// Notes on behaviour
// RQ1 - parameter read opcode 5AH returns table bytes at the command's address
// RQ2 - the basic table begins at address 30H, the header's pointer value
// RQ3 - byte 30H bits 1:0 read 01b, 4 KB erase supported
// RQ4 - byte 30H bit 2 reads 1, write granularity 64 bytes or larger
// RQ5 - byte 30H bits 3 and 4 read 0, nonvolatile status register
// RQ6 - byte 30H bits 7:5 read 111b always
// RQ7 - first word bits 18:17 read 00b, three-byte addressing only
// RQ8 - first word bit 19 reads 0, no double transfer rate
// RQ9 - quad io read: 38H wait 00100b, mode 010b; 39H opcode EBH
// RQ10 - quad output read: wait 01000b, mode 000b; 3BH opcode 6BH
// RQ11 - dual output read: 3CH wait 01000b, mode 000b; 3DH opcode 3BH
// RQ12 - dual io read: wait 00010b, mode 010b; 3FH opcode BBH
// RQ13 - all-dual and all-quad reads unsupported: zero fields, opcodes FFH
// RQ14 - sector size is two to the N; zero means absent, type 4
// RQ15 - sector type 1: size 0CH at 4CH, opcode 20H at 4DH
// RQ16 - sector type 2: size 0FH at 4EH, opcode 52H at 4FH
// RQ17 - sector type 3: size 10H at 50H, opcode D8H at 51H
// RQ18 - bytes 41H to 45H, 48H and 49H read all ones
// RQ19 - each byte at its own address, words least significant byte first
`timescale 1ns/1ps
`include "sfdp_map.svh"
module sfdp_basic_table
  import sfdp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial flash pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  output logic so,
  output logic so_oe_n
);
  logic [`PIN_MSB:0] pin_level;
  logic [`PIN_MSB:0] pin_rise;
  logic [`PIN_MSB:0] pin_fall;
  logic frame;
  logic si_bit;
  logic sclk_rise;
  logic sclk_fall;
  logic shifting;
  logic byte_fall;
  link_state_t state;
  logic [4:0] bit_cnt;
  table_byte_t cmd_shift;
  table_byte_t incoming_op;
  byte_addr_t addr;
  table_byte_t so_shift;
  table_byte_t next_out_byte;

  table_rd_if rd ();

  sfdp_pin_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .raw({cs_n, sclk, si}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  sfdp_table_rom u_rom (
    .rd(rd)
  );

  // edges count only inside a frame; a stray edge after cs_n rises is dropped
  assign frame = ~pin_level[`PIN_CS];
  assign si_bit = pin_level[`PIN_SI];
  assign sclk_rise = pin_rise[`PIN_SCLK] & frame;
  assign sclk_fall = pin_fall[`PIN_SCLK] & frame;
  assign shifting = (state == st_cmd) || (state == st_addr) || (state == st_dummy);
  assign byte_fall = sclk_fall && (state == st_data);
  assign incoming_op = {cmd_shift[`BYTE_MSB-1:0], si_bit};
  assign rd.addr = addr;

  function automatic logic phase_end(input link_state_t s, input logic [4:0] cnt);
    case (s)
      st_cmd: phase_end = (cnt == `BYTE_BIT_LAST);
      st_dummy: phase_end = (cnt == `BYTE_BIT_LAST);
      st_addr: phase_end = (cnt == `ADDR_BIT_LAST);
      default: phase_end = 1'b0;
    endcase
  endfunction : phase_end

  // command framing; any other opcode parks the frame until cs_n rises
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= st_idle;
    end else if (!frame) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          state <= st_cmd;
        end
        st_cmd: begin
          if (sclk_rise && phase_end(state, bit_cnt)) begin
            state <= (incoming_op == `OP_READ_PARAMS) ? st_addr : st_ignore; // see RQ1
          end
        end
        st_addr: begin
          if (sclk_rise && phase_end(state, bit_cnt)) begin
            state <= st_dummy;
          end
        end
        st_dummy: begin
          if (sclk_rise && phase_end(state, bit_cnt)) begin
            state <= st_data;
          end
        end
        st_data: begin
          state <= st_data;
        end
        st_ignore: begin
          state <= st_ignore;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // one counter serves every phase: rising edges in, falling edges out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_cnt <= `CNT_ZERO;
    end else if (!frame || state == st_idle) begin
      bit_cnt <= `CNT_ZERO;
    end else if (sclk_rise && shifting) begin
      bit_cnt <= phase_end(state, bit_cnt) ? `CNT_ZERO : bit_cnt + `CNT_STEP;
    end else if (byte_fall) begin
      bit_cnt <= (bit_cnt == `BYTE_BIT_LAST) ? `CNT_ZERO : bit_cnt + `CNT_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_shift <= `BYTE_ZERO;
    end else if (!frame) begin
      cmd_shift <= `BYTE_ZERO;
    end else if (sclk_rise && state == st_cmd) begin
      cmd_shift <= incoming_op;
    end
  end

  // address is msb first; it wraps at the top of the 24-bit space
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr <= `ADDR_ZERO;
    end else if (sclk_rise && state == st_addr) begin
      addr <= {addr[`ADDR_MSB-1:0], si_bit};
    end else if (byte_fall && bit_cnt == `BYTE_BIT_LAST) begin
      addr <= addr + `ADDR_STEP; // see RQ19
    end
  end

  // a fresh byte is fetched on the first falling edge of each byte
  assign next_out_byte = (bit_cnt == `CNT_ZERO) ? rd.data : so_shift;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      so <= `SO_IDLE;
      so_shift <= `BLANK_BYTE;
    end else if (byte_fall) begin
      so <= next_out_byte[`BYTE_MSB]; // see RQ1
      so_shift <= next_out_byte << 1; // see RQ19
    end
  end

  // so is released as soon as the frame ends so two devices never fight
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      so_oe_n <= 1'b1;
    end else if (!frame) begin
      so_oe_n <= 1'b1;
    end else if (byte_fall) begin
      so_oe_n <= 1'b0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_op_last;
    state == st_cmd && sclk_rise && bit_cnt == `BYTE_BIT_LAST;
  endsequence
  sequence s_byte_start;
    byte_fall && bit_cnt == `CNT_ZERO;
  endsequence
  sequence s_addr_last;
    state == st_addr && sclk_rise && bit_cnt == `ADDR_BIT_LAST;
  endsequence
  sequence s_dummy_last;
    state == st_dummy && sclk_rise && bit_cnt == `BYTE_BIT_LAST;
  endsequence

  property p_op_accept;
    (s_op_last ##0 incoming_op == `OP_READ_PARAMS) |=> state == st_addr && bit_cnt == `CNT_ZERO;
  endproperty
  a_op_accept: assert property (p_op_accept) else $error("read opcode not accepted"); // see RQ1
  property p_op_reject;
    (s_op_last ##0 incoming_op != `OP_READ_PARAMS) |=> state == st_ignore;
  endproperty
  a_op_reject: assert property (p_op_reject) else $error("foreign opcode accepted"); // see RQ1
  property p_quiet_outside_read;
    state != st_data |=> so_oe_n || $past(byte_fall);
  endproperty
  a_quiet_outside_read: assert property (p_quiet_outside_read) else $error("so driven"); // see RQ1
  property p_pointer_first;
    rd.addr == `PARAM_TABLE_POINTER |-> rd.data[`UNUSED_F] == `UNUSED3;
  endproperty
  a_pointer_first: assert property (p_pointer_first) else $error("table start wrong"); // see RQ2
  property p_below_pointer;
    rd.addr < `PARAM_TABLE_POINTER |-> rd.data == `BLANK_BYTE;
  endproperty
  a_below_pointer: assert property (p_below_pointer) else $error("data below table"); // see RQ2
  property p_erase_size;
    rd.addr == `PARAM_TABLE_POINTER |-> rd.data[`ERASE_F] == `ERASE_SIZE_4K;
  endproperty
  a_erase_size: assert property (p_erase_size) else $error("erase size code wrong"); // see RQ3
  property p_write_gran;
    rd.addr == `PARAM_TABLE_POINTER |-> rd.data[`GRAN_F] == `WRITE_GRAN_64;
  endproperty
  a_write_gran: assert property (p_write_gran) else $error("write granularity wrong"); // see RQ4
  property p_vol_wren;
    rd.addr == `PARAM_TABLE_POINTER |-> rd.data[`WREN_F] == {`VOL_WREN_OPSEL, `VOL_WREN_REQ};
  endproperty
  a_vol_wren: assert property (p_vol_wren) else $error("volatile enable bits wrong"); // see RQ5
  property p_unused_top;
    // the byte may only change when the address itself moves
    rd.addr == `PARAM_TABLE_POINTER |-> rd.data[`UNUSED_F] == `UNUSED3
      && ($stable(rd.data) || $changed(rd.addr));
  endproperty
  a_unused_top: assert property (p_unused_top) else $error("unused bits changed"); // see RQ6
  property p_addr_mode;
    rd.addr == table_byte_addr(`PARAM_TABLE_POINTER, `LANE2)
      |-> rd.data[`ADDR_MODE_F] == `ADDR_MODE_3B;
  endproperty
  a_addr_mode: assert property (p_addr_mode) else $error("address mode wrong"); // see RQ7
  property p_dtr;
    rd.addr == table_byte_addr(`PARAM_TABLE_POINTER, `LANE2) |-> rd.data[`DTR_F] == `SUP_DTR;
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr bit wrong"); // see RQ8
  property p_quad_io;
    (rd.addr == `REG_QUAD |-> rd.data == {`MODE_144, `WAIT_144})
      and (rd.addr == table_byte_addr(`REG_QUAD, `LANE1) |-> rd.data == `OP_144);
  endproperty
  a_quad_io: assert property (p_quad_io) else $error("quad io read entry wrong"); // see RQ9
  property p_quad_out;
    (rd.addr == table_byte_addr(`REG_QUAD, `LANE2) |-> rd.data == {`MODE_114, `WAIT_114})
      and (rd.addr == table_byte_addr(`REG_QUAD, `LANE3) |-> rd.data == `OP_114);
  endproperty
  a_quad_out: assert property (p_quad_out) else $error("quad output entry wrong"); // see RQ10
  property p_dual_out;
    (rd.addr == `REG_DUAL |-> rd.data == {`MODE_112, `WAIT_112})
      and (rd.addr == table_byte_addr(`REG_DUAL, `LANE1) |-> rd.data == `OP_112);
  endproperty
  a_dual_out: assert property (p_dual_out) else $error("dual output entry wrong"); // see RQ11
  property p_dual_io;
    (rd.addr == table_byte_addr(`REG_DUAL, `LANE2) |-> rd.data == {`MODE_122, `WAIT_122})
      and (rd.addr == table_byte_addr(`REG_DUAL, `LANE3) |-> rd.data == `OP_122);
  endproperty
  a_dual_io: assert property (p_dual_io) else $error("dual io entry wrong"); // see RQ12
  property p_full_width;
    (rd.addr == `REG_FULL |-> rd.data == {`UNUSED3, `SUP_444, `UNUSED3, `SUP_222})
      and (rd.addr == table_byte_addr(`REG_ALL_DUAL, `LANE2) |-> rd.data == `BYTE_ZERO)
      and (rd.addr == table_byte_addr(`REG_ALL_DUAL, `LANE3) |-> rd.data == `OP_NONE)
      and (rd.addr == table_byte_addr(`REG_ALL_QUAD, `LANE2) |-> rd.data == `BYTE_ZERO)
      and (rd.addr == table_byte_addr(`REG_ALL_QUAD, `LANE3) |-> rd.data == `OP_NONE);
  endproperty
  a_full_width: assert property (p_full_width) else $error("full width read entry wrong"); // see RQ13
  property p_sect4_absent;
    (rd.addr == table_byte_addr(`REG_SECT34, `LANE2) |-> rd.data == `SECT4_SIZE)
      and (rd.addr == table_byte_addr(`REG_SECT34, `LANE3) |-> rd.data == `SECT4_OP);
  endproperty
  a_sect4_absent: assert property (p_sect4_absent) else $error("sector type 4 present"); // see RQ14
  property p_sect1;
    (rd.addr == `REG_SECT12 |-> rd.data == `SECT1_SIZE)
      and (rd.addr == table_byte_addr(`REG_SECT12, `LANE1) |-> rd.data == `SECT1_OP);
  endproperty
  a_sect1: assert property (p_sect1) else $error("sector type 1 wrong"); // see RQ15
  property p_sect2;
    (rd.addr == table_byte_addr(`REG_SECT12, `LANE2) |-> rd.data == `SECT2_SIZE)
      and (rd.addr == table_byte_addr(`REG_SECT12, `LANE3) |-> rd.data == `SECT2_OP);
  endproperty
  a_sect2: assert property (p_sect2) else $error("sector type 2 wrong"); // see RQ16
  property p_sect3;
    (rd.addr == `REG_SECT34 |-> rd.data == `SECT3_SIZE)
      and (rd.addr == table_byte_addr(`REG_SECT34, `LANE1) |-> rd.data == `SECT3_OP);
  endproperty
  a_sect3: assert property (p_sect3) else $error("sector type 3 wrong"); // see RQ17
  property p_unused_bytes;
    (rd.addr > `REG_FULL && rd.addr < table_byte_addr(`REG_ALL_DUAL, `LANE2))
      || rd.addr == `REG_ALL_QUAD || rd.addr == table_byte_addr(`REG_ALL_QUAD, `LANE1)
      |-> rd.data == `BLANK_BYTE;
  endproperty
  a_unused_bytes: assert property (p_unused_bytes) else $error("unused byte not ones"); // see RQ18
  property p_msb_first;
    s_byte_start |=> so == $past(rd.data[`BYTE_MSB]) && !so_oe_n;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("byte not sent msb first"); // see RQ19
  property p_next_byte;
    byte_fall && bit_cnt == `BYTE_BIT_LAST |=> addr == $past(addr) + `ADDR_STEP;
  endproperty
  a_next_byte: assert property (p_next_byte) else $error("address did not step"); // see RQ19
  property p_shift_on;
    byte_fall && bit_cnt != `CNT_ZERO |=> so == $past(so_shift[`BYTE_MSB]);
  endproperty
  a_shift_on: assert property (p_shift_on) else $error("wrong bit shifted out"); // see RQ19
  property p_cmd_step;
    state == st_cmd && sclk_rise && bit_cnt != `BYTE_BIT_LAST
      |=> state == st_cmd && bit_cnt == $past(bit_cnt) + `CNT_STEP;
  endproperty
  a_cmd_step: assert property (p_cmd_step) else $error("opcode bit miscounted"); // see RQ1
  property p_addr_shift;
    sclk_rise && state == st_addr |=> addr[0] == $past(si_bit)
      && addr[`ADDR_MSB:1] == $past(addr[`ADDR_MSB-1:0]);
  endproperty
  a_addr_shift: assert property (p_addr_shift) else $error("address bit lost"); // see RQ1
  property p_addr_to_dummy;
    s_addr_last |=> state == st_dummy && bit_cnt == `CNT_ZERO;
  endproperty
  a_addr_to_dummy: assert property (p_addr_to_dummy) else $error("no dummy phase"); // see RQ1
  property p_dummy_to_data;
    s_dummy_last |=> state == st_data && bit_cnt == `CNT_ZERO;
  endproperty
  a_dummy_to_data: assert property (p_dummy_to_data) else $error("no data phase"); // see RQ1
  property p_ignore_stays;
    state == st_ignore && frame |=> state == st_ignore && so_oe_n;
  endproperty
  a_ignore_stays: assert property (p_ignore_stays) else $error("refused frame woke up"); // see RQ1
  property p_release_on_end;
    !frame |=> so_oe_n && state == st_idle;
  endproperty
  a_release_on_end: assert property (p_release_on_end) else $error("so not released"); // see RQ1
  property p_oe_hold;
    !so_oe_n && frame |=> !so_oe_n;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("so dropped inside frame"); // see RQ1
  property p_above_table;
    rd.addr > table_byte_addr(`REG_SECT34, `LANE3) |-> rd.data == `BLANK_BYTE;
  endproperty
  a_above_table: assert property (p_above_table) else $error("data above table"); // see RQ2
endmodule : sfdp_basic_table

//--- logic/sfdp_map.svh
// sfdp_map: named offsets, field positions and fixed values of the basic table
// assumes: included by bare name from every design file that needs a figure
`ifndef SFDP_MAP_SVH
`define SFDP_MAP_SVH
// pin positions inside the synchroniser vector
`define PIN_MSB 2
`define PIN_CS 2
`define PIN_SCLK 1
`define PIN_SI 0
`define SYNC_RESET 3'h6
// command framing
`define OP_READ_PARAMS 8'h5A
`define BYTE_BIT_LAST 5'h07
`define ADDR_BIT_LAST 5'h17
`define CNT_ZERO 5'h00
`define CNT_STEP 5'h01
`define ADDR_MSB 23
`define ADDR_ZERO 24'h00_0000
`define ADDR_STEP 24'h00_0001
`define BYTE_MSB 7
`define BYTE_ZERO 8'h00
`define BLANK_BYTE 8'hFF
`define SO_IDLE 1'h1
// table placement, one word per register, bytes least significant first
`define LANE_BITS 2
`define LANE0 2'h0
`define LANE1 2'h1
`define LANE2 2'h2
`define LANE3 2'h3
`define PARAM_TABLE_POINTER 24'h00_0030
`define REG_DENSITY 24'h00_0034
`define REG_QUAD 24'h00_0038
`define REG_DUAL 24'h00_003C
`define REG_FULL 24'h00_0040
`define REG_ALL_DUAL 24'h00_0044
`define REG_ALL_QUAD 24'h00_0048
`define REG_SECT12 24'h00_004C
`define REG_SECT34 24'h00_0050
// field positions inside a byte
`define ERASE_F 1:0
`define GRAN_F 2
`define WREN_F 4:3
`define UNUSED_F 7:5
`define ADDR_MODE_F 2:1
`define DTR_F 3
`define WAIT_F 4:0
`define MODE_F 7:5
// field values
`define ERASE_SIZE_4K 2'h1
`define WRITE_GRAN_64 1'h1
`define VOL_WREN_REQ 1'h0
`define VOL_WREN_OPSEL 1'h0
`define UNUSED3 3'h7
`define UNUSED1 1'h1
`define OP_ERASE_4K 8'h20
`define SUP_112 1'h1
`define ADDR_MODE_3B 2'h0
`define SUP_DTR 1'h0
`define SUP_122 1'h1
`define SUP_144 1'h1
`define SUP_114 1'h1
`define DENSITY 32'h00FF_FFFF
`define WAIT_144 5'h04
`define MODE_144 3'h2
`define OP_144 8'hEB
`define WAIT_114 5'h08
`define MODE_114 3'h0
`define OP_114 8'h6B
`define WAIT_112 5'h08
`define MODE_112 3'h0
`define OP_112 8'h3B
`define WAIT_122 5'h02
`define MODE_122 3'h2
`define OP_122 8'hBB
`define SUP_222 1'h0
`define SUP_444 1'h0
`define WAIT_NONE 5'h00
`define MODE_NONE 3'h0
`define OP_NONE 8'hFF
`define SECT1_SIZE 8'h0C
`define SECT1_OP 8'h20
`define SECT2_SIZE 8'h0F
`define SECT2_OP 8'h52
`define SECT3_SIZE 8'h10
`define SECT3_OP 8'hD8
`define SECT4_SIZE 8'h00
`define SECT4_OP 8'hFF
`endif

//--- logic/sfdp_pkg.sv
// sfdp_pkg: types shared by the table read port and its table
// assumes: sfdp_map.svh is on the include path
`include "sfdp_map.svh"
package sfdp_pkg;
  typedef logic [`ADDR_MSB:0] byte_addr_t;
  typedef logic [`BYTE_MSB:0] table_byte_t;
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_cmd = 3'h1,
    st_addr = 3'h3,
    st_dummy = 3'h2,
    st_data = 3'h6,
    st_ignore = 3'h7
  } link_state_t;
  function automatic byte_addr_t table_byte_addr(input byte_addr_t base, input logic [1:0] lane);
    table_byte_addr = {base[`ADDR_MSB:`LANE_BITS], lane};
  endfunction : table_byte_addr
endpackage : sfdp_pkg

//--- logic/table_rd_if.sv
// table_rd_if: byte address out to the table, byte back
// assumes: the table answers combinationally in the same cycle
`timescale 1ns/1ps
interface table_rd_if;
  import sfdp_pkg::*;
  byte_addr_t addr;
  table_byte_t data;
  modport reader (output addr, input data);
  modport rom (input addr, output data);
endinterface : table_rd_if

//--- logic/sfdp_pin_sync.sv
// sfdp_pin_sync: two-flop synchronisers for the serial pins plus edge pulses
// assumes: pins are asynchronous to clk and far slower than it
`timescale 1ns/1ps
`include "sfdp_map.svh"
module sfdp_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw pins and their synchronised views
  input wire logic [`PIN_MSB:0] raw,
  output logic [`PIN_MSB:0] level,
  output logic [`PIN_MSB:0] rise,
  output logic [`PIN_MSB:0] fall
);
  localparam logic [`PIN_MSB:0] reset_value = `SYNC_RESET;
  logic [`PIN_MSB:0] meta;
  logic [`PIN_MSB:0] stable;
  logic [`PIN_MSB:0] last;
  // meta feeds only stable; edges compare stable with last
  for (genvar i = 0; i <= `PIN_MSB; i++) begin : g_pin
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        meta[i] <= reset_value[i];
        stable[i] <= reset_value[i];
        last[i] <= reset_value[i];
      end else begin
        meta[i] <= raw[i];
        stable[i] <= meta[i];
        last[i] <= stable[i];
      end
    end
    assign level[i] = stable[i];
    assign rise[i] = stable[i] & ~last[i];
    assign fall[i] = ~stable[i] & last[i];
  end
endmodule : sfdp_pin_sync

//--- logic/sfdp_table_rom.sv
// sfdp_table_rom: the basic parameter words, one byte per address
// assumes: any address outside the table reads as all ones
`timescale 1ns/1ps
`include "sfdp_map.svh"
module sfdp_table_rom
  import sfdp_pkg::*;
(
  // byte read port
  table_rd_if.rom rd
);
  function automatic logic [31:0] dword_at(input byte_addr_t a);
    case (table_byte_addr(a, `LANE0))
      `PARAM_TABLE_POINTER: dword_at = {{8{1'b1}}, // see RQ2
        {`UNUSED1, `SUP_114, `SUP_144, `SUP_122, `SUP_DTR, `ADDR_MODE_3B, `SUP_112}, // see RQ7 RQ8
        `OP_ERASE_4K,
        {`UNUSED3, `VOL_WREN_OPSEL, `VOL_WREN_REQ, // see RQ5 RQ6
        `WRITE_GRAN_64, `ERASE_SIZE_4K}}; // see RQ3 RQ4
      `REG_DENSITY: dword_at = `DENSITY;
      `REG_QUAD: dword_at = {`OP_114, `MODE_114, `WAIT_114, // see RQ10
        `OP_144, `MODE_144, `WAIT_144}; // see RQ9
      `REG_DUAL: dword_at = {`OP_122, `MODE_122, `WAIT_122, // see RQ12
        `OP_112, `MODE_112, `WAIT_112}; // see RQ11
      `REG_FULL: dword_at = {{24{1'b1}}, `UNUSED3, `SUP_444, `UNUSED3, `SUP_222}; // see RQ13 RQ18
      `REG_ALL_DUAL: dword_at = {`OP_NONE, `MODE_NONE, `WAIT_NONE, {16{1'b1}}}; // see RQ13 RQ18
      `REG_ALL_QUAD: dword_at = {`OP_NONE, `MODE_NONE, `WAIT_NONE, {16{1'b1}}}; // see RQ13 RQ18
      `REG_SECT12: dword_at = {`SECT2_OP, `SECT2_SIZE, `SECT1_OP, `SECT1_SIZE}; // see RQ15 RQ16
      `REG_SECT34: dword_at = {`SECT4_OP, `SECT4_SIZE, `SECT3_OP, `SECT3_SIZE}; // see RQ14 RQ17
      default: dword_at = {4{`BLANK_BYTE}};
    endcase
  endfunction : dword_at
  function automatic table_byte_t byte_of(input logic [31:0] w, input logic [1:0] lane);
    case (lane)
      `LANE0: byte_of = w[7:0];
      `LANE1: byte_of = w[15:8];
      `LANE2: byte_of = w[23:16];
      default: byte_of = w[31:24];
    endcase
  endfunction : byte_of
  // least significant byte of each word at the lowest address
  assign rd.data = byte_of(dword_at(rd.addr), rd.addr[`LANE_BITS-1:0]); // see RQ19
endmodule : sfdp_table_rom

//--- bench/flash_host.sv
// flash_host: host controller model issuing parameter reads over a 1-1-1 serial link
// assumes: clk is the device clock; mode 0, sclk idles low and stands still between frames
`timescale 1ns/1ps
module flash_host (
  // clock
  input wire logic clk,
  // serial flash pins
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  logic [7:0] rx [0:63];
  int oe_low_cnt;
  // clk periods per sclk phase; the device needs at least 4
  int half_clks = 5;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // cut stops the frame after that many sclk pulses, 0 runs it whole
  task automatic xfer(input logic [7:0] op, input logic [23:0] addr, input int nbytes,
                      input int cut);
    logic [31:0] cmd;
    logic q;
    logic oe;
    int total;
    begin
      cmd = {op, addr};
      total = 40 + 8 * nbytes;
      oe_low_cnt = 0;
      @(posedge clk);
      #2 cs_n = 1'b0;
      for (int j = 0; j < total; j++) begin
        if (cut != 0 && j == cut) break;
        // dummy and data phases carry a changing si so the device cannot lean on it
        if (j < 32) si = cmd[31 - j];
        else si = ~si;
        repeat (half_clks) @(posedge clk);
        #2;
        // a released so shows the inverse of its last bit, so a stray sample shows up
        q = (so_oe_n === 1'b0) ? so : ~so;
        oe = so_oe_n;
        sclk = 1'b1;
        if (j >= 40) rx[(j - 40) / 8] = {rx[(j - 40) / 8][6:0], q};
        if (oe === 1'b0) oe_low_cnt++;
        repeat (half_clks) @(posedge clk);
        #2 sclk = 1'b0;
      end
      repeat (half_clks) @(posedge clk);
      #2 cs_n = 1'b1;
      si = ~si;
      repeat (8) @(posedge clk);
    end
  endtask : xfer
endmodule : flash_host

//--- bench/sfdp_basic_table_tb.sv
// sfdp_basic_table_tb: self-checking bench reading the parameter table through the host model
// assumes: flash_host drives the pins; 50 ns clock; expected bytes written out by hand
`timescale 1ns/1ps
module sfdp_basic_table_tb;
  logic clk;
  logic rst_n;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  logic so_oe_n;
  int bad_count = 0;
  int num_checks = 0;
  // rows: table address in the upper byte, expected byte in the lower
  logic [15:0] rows [0:37] = '{
    16'h2FFF, 16'h30E5, 16'h3120, 16'h32F1, 16'h33FF, 16'h34FF,
    16'h35FF, 16'h36FF, 16'h3700, 16'h3844, 16'h39EB, 16'h3A08,
    16'h3B6B, 16'h3C08, 16'h3D3B, 16'h3E42, 16'h3FBB, 16'h40EE,
    16'h41FF, 16'h42FF, 16'h43FF, 16'h44FF, 16'h45FF, 16'h4600,
    16'h47FF, 16'h48FF, 16'h49FF, 16'h4A00, 16'h4BFF, 16'h4C0C,
    16'h4D20, 16'h4E0F, 16'h4F52, 16'h5010, 16'h51D8, 16'h5200,
    16'h53FF, 16'h54FF};

  sfdp_basic_table dut (
    .clk(clk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .sclk(sclk),
    .si(si),
    .so(so),
    .so_oe_n(so_oe_n)
  );

  flash_host host (
    .clk(clk),
    .cs_n(cs_n),
    .sclk(sclk),
    .si(si),
    .so(so),
    .so_oe_n(so_oe_n)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] want);
    num_checks++;
    if (got !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
    end
  endtask : check

  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    exp_byte = 8'hFF;
    foreach (rows[i]) if (rows[i][15:8] == a) exp_byte = rows[i][7:0];
  endfunction : exp_byte

  // every frame must leave the output released once cs_n is back high
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n, input int cut);
    host.xfer(op, a, n, cut);
    check({7'h00, so_oe_n}, 8'h01);
  endtask : frame

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    #3_000_000;
    bad_count++;
    $display("watchdog expired at %0t", $time);
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    #2;
    check({6'h00, so, so_oe_n}, 8'h03);
    rst_n = 1'b1;
    @(posedge clk);
    #2;
    check({6'h00, so, so_oe_n}, 8'h03);
    $display("reset test done");
    // one single-byte frame per row
    foreach (rows[i]) begin
      frame(8'h5A, {16'h0000, rows[i][15:8]}, 1, 0);
      check(host.rx[0], rows[i][7:0]);
      check(host.oe_low_cnt[7:0], 8'h08);
    end
    $display("table rows test done");
    // slow host, burst across both ends of the table with auto-increment
    host.half_clks = 9;
    frame(8'h5A, 24'h00_002E, 40, 0);
    for (int k = 0; k < 40; k++) begin
      check(host.rx[k], exp_byte(8'h2E + k[7:0]));
    end
    host.half_clks = 5;
    $display("burst test done");
    // another opcode never drives so
    frame(8'h03, 24'h00_0030, 2, 0);
    check(host.oe_low_cnt[7:0], 8'h00);
    $display("refused opcode test done");
    // abort in the address, then in mid data, then a clean frame
    frame(8'h5A, 24'h00_0030, 1, 20);
    frame(8'h5A, 24'h00_0030, 2, 44);
    frame(8'h5A, 24'h00_003D, 1, 0);
    check(host.rx[0], 8'h3B);
    check(host.oe_low_cnt[7:0], 8'h08);
    $display("abort test done");
    test_done();
  end
endmodule : sfdp_basic_table_tb
